// >>> logic/csxt_pkg.sv
package csxt_pkg;
	// Terminal count and function codes
	localparam int NUM_TERM = 6;
	localparam logic [5:0] FUNC_COAST = 6'h0B;
	localparam logic [5:0] FUNC_EXT_FAULT = 6'h0C;
	localparam logic [5:0] FUNC_NONE = 6'h3F;
	// Fault codes reported on fault_code
	localparam logic [7:0] FAULT_NONE = 8'h00;
	localparam logic [7:0] FAULT_EXT = 8'h0C;
	localparam logic [7:0] FAULT_START_GUARD = 8'h0D;
	// Restart wait time: programmed in units of 100 ms
	localparam int WAIT_UNIT_NS = 100000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int WAIT_UNIT_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
	localparam int HIST_DEPTH = 4;
	localparam logic [15:0] SPEED_ZERO = 16'h0000;
	// Restart speed select values
	localparam logic RESTART_FROM_ZERO = 1'b0;
	localparam logic RESTART_FROM_SPEED = 1'b1;
endpackage

// >>> logic/csxt_input_cond.sv
`timescale 1ns/1ps
`default_nettype none
// Per-terminal synchroniser, polarity and edge detect
module csxt_input_cond (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [5:0] term_in,
	input wire logic [5:0] term_invert,
	output logic [5:0] term_level,
	output logic [5:0] term_rise
);
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] lvl_q;
	logic primed_q;
	genvar i;

	// Blocks edges on the first cycle out of reset, where lvl_q is not yet the idle level
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			primed_q <= 1'b0;
		end else begin
			primed_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	generate
		for (i = 0; i < csxt_pkg::NUM_TERM; i++) begin : g_term
			// Two-stage sync; only stage two is looked at
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					sync1_q[i] <= 1'b0;
					sync2_q[i] <= 1'b0;
					lvl_q[i] <= 1'b0;
				end else begin
					sync1_q[i] <= term_in[i];
					sync2_q[i] <= sync1_q[i];
					lvl_q[i] <= sync2_q[i] ^ term_invert[i];
				end
			end
			assign term_level[i] = lvl_q[i];
			assign term_rise[i] = (sync2_q[i] ^ term_invert[i]) & ~lvl_q[i] & primed_q;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> logic/csxt_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - An asserted coast-stop input cuts the output at once so the motor coasts.
// - Releasing coast-stop resumes drive only if the run command is still active.
// - Restart speed select picks a resume from zero or from the present motor speed.
// - A restart wait is inserted after coast-stop release, and zero means no wait.
// - Every terminal has a polarity setting so coast-stop can be active low.
// - A rising external-fault input latches a trip, reports E12 and stops output.
// - Dropping the external-fault input neither clears the trip nor makes an event.
// - An external trip lets the motor coast and raises the alarm with no ramp.
// - If run is still active when reset is released and start guard is off, the drive restarts.
// - External trip events stay in the fault history until a reset is done; guard trips are not logged.
// - With start guard, no automatic restart when the trip is reset; wait for a fresh run edge.
// - With start guard, a run already active at power-up is refused.
module csxt_core (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [5:0] term_in,
	input wire logic [35:0] input_function_assignments,
	input wire logic [5:0] input_polarity_settings,
	input wire logic run_cmd,
	input wire logic reset_cmd,
	input wire logic start_guard,
	input wire logic restart_speed_select,
	input wire logic [7:0] restart_wait_time,
	input wire logic [15:0] motor_speed,
	output logic drive_enable,
	output logic coasting,
	output logic alarm,
	output logic [7:0] fault_code,
	output logic [15:0] restart_speed,
	output logic restart_load,
	output logic [31:0] fault_history
);
	typedef enum logic [4:0] {
		CSXT_STOP = 5'b00001,
		CSXT_RUN = 5'b00010,
		CSXT_COAST = 5'b00100,
		CSXT_WAIT = 5'b01000,
		CSXT_TRIP = 5'b10000
	} csxt_state_t;

	csxt_state_t state_q;
	logic [5:0] term_level;
	logic [5:0] term_rise;
	logic coast_act;
	logic ext_rise;
	logic run_q;
	logic run_rise;
	logic reset_q;
	logic reset_fall;
	logic guard_q;
	logic first_q;
	logic [7:0] wait_units_q;
	logic [22:0] wait_cyc_q;
	logic wait_done;

	////////////////////////////////////////////////////////////////////////////
	// Input conditioning
	// per-terminal polarity
	csxt_input_cond u_cond (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.term_in(term_in),
		.term_invert(input_polarity_settings),
		.term_level(term_level),
		.term_rise(term_rise)
	);

	// Gather function hits across terminals
	always_comb begin
		coast_act = 1'b0;
		ext_rise = 1'b0;
		for (int k = 0; k < csxt_pkg::NUM_TERM; k++) begin
			if (input_function_assignments[k*6 +: 6] == csxt_pkg::FUNC_COAST) begin
				coast_act = coast_act | term_level[k];
			end
			if (input_function_assignments[k*6 +: 6] == csxt_pkg::FUNC_EXT_FAULT) begin
				ext_rise = ext_rise | term_rise[k];
			end
		end
	end

	// Command edge detectors
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			run_q <= 1'b0;
			reset_q <= 1'b0;
			first_q <= 1'b1;
		end else begin
			run_q <= run_cmd;
			reset_q <= reset_cmd;
			first_q <= 1'b0;
		end
	end
	assign run_rise = run_cmd & ~run_q;
	assign reset_fall = reset_q & ~reset_cmd;

	////////////////////////////////////////////////////////////////////////////
	// Restart wait timer; zero programmed units skips it
	assign wait_done = (wait_units_q == 8'h00);
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wait_units_q <= 8'h00;
			wait_cyc_q <= 23'h000000;
		end else if (state_q == CSXT_COAST) begin
			wait_units_q <= restart_wait_time;
			wait_cyc_q <= 23'h000000;
		end else if (state_q == CSXT_WAIT && !wait_done) begin
			if (wait_cyc_q == 23'(csxt_pkg::WAIT_UNIT_CYC - 1)) begin
				wait_cyc_q <= 23'h000000;
				wait_units_q <= wait_units_q - 8'h01;
			end else begin
				wait_cyc_q <= wait_cyc_q + 23'h000001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Main state machine; trip has priority over coast and run
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= CSXT_STOP;
			guard_q <= 1'b0;
		end else begin
			case (state_q)
				CSXT_STOP: begin
					if (ext_rise) begin
						state_q <= CSXT_TRIP;
					end else if (first_q && start_guard && run_cmd) begin
						guard_q <= 1'b1;
						state_q <= CSXT_TRIP;
					end else if (run_cmd && !coast_act && (!start_guard || run_rise)) begin
						// guard wants a fresh run edge once stopped
						state_q <= CSXT_RUN;
					end
				end
				CSXT_RUN: begin
					if (ext_rise) begin
						state_q <= CSXT_TRIP;
					end else if (coast_act) begin
						state_q <= CSXT_COAST;
					end else if (!run_cmd) begin
						state_q <= CSXT_STOP;
					end
				end
				CSXT_COAST: begin
					if (ext_rise) begin
						state_q <= CSXT_TRIP;
					end else if (!coast_act) begin
						state_q <= run_cmd ? CSXT_WAIT : CSXT_STOP;
					end
				end
				CSXT_WAIT: begin
					if (ext_rise) begin
						state_q <= CSXT_TRIP;
					end else if (coast_act) begin
						state_q <= CSXT_COAST;
					end else if (!run_cmd) begin
						state_q <= CSXT_STOP;
					end else if (wait_done) begin
						state_q <= CSXT_RUN;
					end
				end
				CSXT_TRIP: begin
					if (reset_fall) begin
						guard_q <= 1'b0;
						if (run_cmd && !start_guard && !coast_act) begin
							state_q <= CSXT_RUN;
						end else begin
							state_q <= CSXT_STOP;
						end
					end else if (guard_q && run_rise && !reset_cmd) begin
						// fresh run edge clears guard trip
						guard_q <= 1'b0;
						state_q <= CSXT_RUN;
					end else if (guard_q && !run_cmd && !start_guard) begin
						guard_q <= 1'b0;
						state_q <= CSXT_STOP;
					end
				end
				default: begin
					state_q <= CSXT_STOP;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			drive_enable <= 1'b0;
			coasting <= 1'b0;
			alarm <= 1'b0;
			fault_code <= csxt_pkg::FAULT_NONE;
		end else begin
			drive_enable <= (state_q == CSXT_RUN) && !coast_act && !ext_rise;
			coasting <= (state_q == CSXT_COAST) || (state_q == CSXT_TRIP);
			alarm <= (state_q == CSXT_TRIP) || ext_rise;
			if (ext_rise) begin
				fault_code <= csxt_pkg::FAULT_EXT;
			end else if (state_q == CSXT_TRIP && guard_q) begin
				fault_code <= csxt_pkg::FAULT_START_GUARD;
			end else if (state_q != CSXT_TRIP) begin
				fault_code <= csxt_pkg::FAULT_NONE;
			end
		end
	end

	// Restart speed strobe when leaving the wait
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			restart_speed <= csxt_pkg::SPEED_ZERO;
			restart_load <= 1'b0;
		end else begin
			restart_load <= (state_q == CSXT_WAIT) && wait_done && run_cmd && !coast_act
				&& !ext_rise;
			if (restart_speed_select == csxt_pkg::RESTART_FROM_SPEED) begin
				restart_speed <= motor_speed;
			end else begin
				restart_speed <= csxt_pkg::SPEED_ZERO;
			end
		end
	end

	// Fault history: newest code in the low byte, kept until reset
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			fault_history <= 32'h00000000;
		end else if (ext_rise) begin
			fault_history <= {fault_history[23:0], csxt_pkg::FAULT_EXT};
		end else if (reset_fall) begin
			fault_history <= 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// >>> verification/csxt_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the core
module csxt_props (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic run_cmd,
	input wire logic reset_cmd,
	input wire logic start_guard,
	input wire logic restart_speed_select,
	input wire logic [15:0] motor_speed,
	input wire logic drive_enable,
	input wire logic coasting,
	input wire logic alarm,
	input wire logic [7:0] fault_code,
	input wire logic [15:0] restart_speed,
	input wire logic restart_load
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Run already held when reset lets go, with the guard on
	sequence s_guard_up;
		$fell(sys_rst) && start_guard && run_cmd;
	endsequence
	sequence s_guard_trip;
		##[1:4] fault_code == csxt_pkg::FAULT_START_GUARD;
	endsequence
	a_coast_no_drive: assert property (coasting |-> !drive_enable)
		else $error("drive on while coasting");
	a_trip_no_drive: assert property (alarm |-> !drive_enable)
		else $error("drive on while tripped");
	a_trip_has_code: assert property (alarm |-> fault_code != csxt_pkg::FAULT_NONE)
		else $error("alarm without fault code");
	// Three quiet samples of reset_cmd (now and two back) rule out a late falling edge
	a_trip_holds: assert property (alarm && !reset_cmd && !$past(reset_cmd)
		&& !$past(reset_cmd, 2) |=> alarm)
		else $error("alarm dropped without reset");
	a_load_single: assert property (restart_load |=> !restart_load)
		else $error("restart load longer than one cycle");
	a_load_drives: assert property (restart_load |=> drive_enable)
		else $error("no drive after restart load");
	a_speed_pick: assert property (!$past(sys_rst) |-> restart_speed ==
		($past(restart_speed_select) ? $past(motor_speed) : 16'h0000))
		else $error("wrong restart speed");
	a_guard_refuse: assert property (s_guard_up |-> s_guard_trip)
		else $error("run at power-up not refused");
endmodule
bind csxt_core csxt_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.run_cmd(run_cmd), .reset_cmd(reset_cmd), .start_guard(start_guard),
	.restart_speed_select(restart_speed_select), .motor_speed(motor_speed),
	.drive_enable(drive_enable), .coasting(coasting), .alarm(alarm),
	.fault_code(fault_code), .restart_speed(restart_speed), .restart_load(restart_load));
`default_nettype wire

// >>> verification/csxt_motor.sv
`timescale 1ns/1ps
`default_nettype none
// Motor stage: speed builds under drive, decays while coasting
module csxt_motor (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic drive_enable,
	output logic [15:0] motor_speed
);
	// Slow decay keeps a nonzero speed to catch on restart
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			motor_speed <= 16'h0000;
		end else if (drive_enable) begin
			motor_speed <= motor_speed + 16'h0003;
		end else if (motor_speed != 16'h0000) begin
			motor_speed <= motor_speed - 16'h0001;
		end
	end
endmodule
`default_nettype wire

// >>> verification/coast_stop_and_external_trip_tb.sv
`timescale 1ns/1ps
`default_nettype none
module coast_stop_and_external_trip_tb;
	logic core_clk = 0;
	logic sys_rst = 1;
	logic run = 0;
	logic rst_cmd = 0;
	logic guard = 0;
	logic sel = 0;
	logic [5:0] term = 6'h00;
	logic [5:0] pol = 6'h00;
	logic [35:0] fn = 36'hFFFFFFFFF;
	logic drv, coast, alarm, load;
	logic [2:0] f;
	logic [7:0] code;
	logic [15:0] spd, rspd, ms_prev;
	logic [31:0] hist;
	int num_errors = 0;
	int n_compared = 0;
	int seed = 32'hA550;
	int c, e, w;
	int q[$];
	assign f = {load, alarm, drv};
	initial forever #25 core_clk = ~core_clk;
	csxt_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .term_in(term),
		.input_function_assignments(fn), .input_polarity_settings(pol), .run_cmd(run),
		.reset_cmd(rst_cmd), .start_guard(guard), .restart_speed_select(sel),
		.restart_wait_time(8'h00), .motor_speed(spd), .drive_enable(drv), .coasting(coast),
		.alarm(alarm), .fault_code(code), .restart_speed(rspd), .restart_load(load),
		.fault_history(hist));
	csxt_motor u_motor (.core_clk(core_clk), .sys_rst(sys_rst), .drive_enable(drv),
		.motor_speed(spd));
	////////////////////////////////////////////////////////////////
	task finish_test();
		if (num_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded flag wait; ms_prev trails the motor speed by one cycle
	task wt(input int k, input logic v);
		for (w = 0; w < 60; w++) begin
			@(negedge core_clk);
			if (f[k] === v) return;
			ms_prev = spd;
		end
		num_errors++;
		finish_test();
	endtask
	task pulse_rst();
		rst_cmd = 1;
		repeat (2) @(negedge core_clk);
		rst_cmd = 0;
		q.delete();
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		// Random terminal slots so any input can carry either function
		c = $unsigned($random(seed)) % 6;
		e = (c + 1 + $unsigned($random(seed)) % 5) % 6;
		fn[c*6 +: 6] = csxt_pkg::FUNC_COAST;
		fn[e*6 +: 6] = csxt_pkg::FUNC_EXT_FAULT;
		repeat (20) @(negedge core_clk);
		sys_rst = 0;
		chk("drive", drv, 0);
		run = 1;
		wt(0, 1);
		// Coast and resume: both speeds, active high then active low
		for (int i = 0; i < 2; i++) begin
			repeat (16) @(negedge core_clk);
			sel = i;
			pol[c] = i;
			term[c] = !i;
			wt(0, 0);
			// Coasting follows the state, one cycle after drive drops
			@(negedge core_clk);
			chk("coasting", coast, 1);
			repeat (4) @(negedge core_clk);
			term[c] = i;
			wt(2, 1);
			chk("restart_speed", rspd, i ? ms_prev : 16'h0000);
			wt(0, 1);
		end
		// External trip latches and outlives its input
		term[e] = 1;
		wt(1, 1);
		q.push_back(csxt_pkg::FAULT_EXT);
		chk("fault_code", code, q[0]);
		chk("drive", drv, 0);
		term[e] = 0;
		repeat (10) @(negedge core_clk);
		chk("alarm", alarm, 1);
		chk("history", hist, q[0]);
		pulse_rst();
		wt(1, 0);
		chk("history", hist, 0);
		wt(0, 1);
		// Guard: refuse held run at power-up, then need a fresh run edge
		guard = 1;
		sys_rst = 1;
		repeat (2) @(negedge core_clk);
		sys_rst = 0;
		repeat (4) @(negedge core_clk);
		chk("fault_code", code, csxt_pkg::FAULT_START_GUARD);
		chk("drive", drv, 0);
		pulse_rst();
		run = 0;
		@(negedge core_clk);
		run = 1;
		wt(0, 1);
		term[e] = 1;
		wt(1, 1);
		term[e] = 0;
		pulse_rst();
		wt(1, 0);
		repeat (10) @(negedge core_clk);
		chk("drive", drv, 0);
		run = 0;
		@(negedge core_clk);
		run = 1;
		wt(0, 1);
		finish_test();
	end
endmodule
`default_nettype wire
